// File: rtl/dpmc_top.sv
// Summary of operation
// - six-bit selection word, one function per bit
// - bit 0 enables automatic carrier lowering
// - lower carrier near overheat or overload
// - bit 1 enables input phase loss detection
// - input phase loss stops output, alarms
// - bit 2: output phase loss while running trips
// - all three phases lost does not trip
// - bit 3 picks factory or user reference
// - bit 4 enables capacitor life judgment
// - time bus discharge, compare with reference
// - fan lock only on fitted larger ratings
// - bit 5: alarm or continue on lock
// - lock alarm removes output, motor coasts
// - lock always drives overheat and life warnings
// - commanded fan stop makes lock count normal
// - condensation command needs input function 39
// - condensation starts on command while stopped
// - pulse uses brake level and brake time
// - interval set so on-time over on-time plus interval equals duty
//
// Register access over APB and the register addresses were left to the implementer.
module dpmc_top #(
  parameter int          TICK_CYCLES     = dpmc_pkg::TICK_CYCLES,
  parameter logic [15:0] CAP_REF_FACTORY = dpmc_pkg::CAP_REF_FACTORY
) (
  // clock and reset
  input  wire logic        CORE_CLK,
  input  wire logic        RST_N,
  // apb slave
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  // drive state
  input  wire logic        RUN_CMD,
  input  wire logic        RUNNING,
  // detectors
  input  wire logic        HS_OVERHEAT_NEAR,
  input  wire logic        OVERLOAD_NEAR,
  input  wire logic        IN_PHASE_LOSS,
  input  wire logic [2:0]  OUT_PHASE_LOST,
  input  wire logic        FAN_FITTED,
  input  wire logic        DC_FAN_LOCK,
  input  wire logic        POWER_OFF,
  input  wire logic        DC_BUS_LOW,
  // general-purpose digital input carrying the condensation command
  input  wire logic        DI_TERMINAL,
  // drive controls
  output logic             OUTPUT_ENABLE,
  output logic             CARRIER_LOWER,
  output logic             FAN_RUN_CMD,
  output logic             DC_INJECT_EN,
  output logic      [7:0]  DC_INJECT_LEVEL,
  // alarms and warnings
  output logic             ALM_IN_PHASE,
  output logic             ALM_OUT_PHASE,
  output logic             ALM_FAN_LOCK,
  output logic             OVERHEAT_WARNING_OUT,
  output logic             LIFE_WARNING_OUT,
  output logic             CAP_LIFE_EXPIRED
);
  dpmc_ctl_if ctl ();

  // register file
  logic [5:0]  protection_maintenance_select;
  logic [31:0] config_reg;
  logic [7:0]  condensation_duty_setting;
  logic [7:0]  dc_brake_level_setting;
  logic [15:0] dc_brake_time_setting;
  logic [15:0] cap_ref_user;
  logic [15:0] cap_meas;
  logic        cap_valid;

  // derived controls
  logic        cooling_fan_onoff_control;
  logic [7:0]  di_func;
  logic        condensation_prevention_cmd;
  logic        drive_stopped;
  logic        fan_lock_valid;
  logic        out_loss_partial;
  logic        any_trip;
  logic [15:0] cap_ref;

  // apb decode
  logic        setup;
  logic        access;
  logic        wr;
  logic        mapped;
  logic [9:0]  status;
  logic [31:0] clr_mask;

  // tick prescaler
  logic [31:0] tick_cnt;
  logic        tick;

  assign setup  = PSEL && !PENABLE;
  assign access = PSEL && PENABLE;
  assign wr     = access && PWRITE;

  always_comb begin
    case (PADDR)
      dpmc_pkg::OFS_SELECT, dpmc_pkg::OFS_CONFIG, dpmc_pkg::OFS_DEW_DUTY,
      dpmc_pkg::OFS_BRK_LEVEL, dpmc_pkg::OFS_BRK_TIME, dpmc_pkg::OFS_CAP_REF,
      dpmc_pkg::OFS_STATUS, dpmc_pkg::OFS_CLEAR, dpmc_pkg::OFS_CAP_MEAS: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  // zero wait states; read data latched in the setup cycle
  assign PREADY  = 1'b1;
  assign PSLVERR = access && !mapped;
  assign clr_mask = (wr && PADDR == dpmc_pkg::OFS_CLEAR) ? PWDATA : 32'h0000_0000;

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      protection_maintenance_select <= dpmc_pkg::SELECT_RST;
      config_reg                    <= dpmc_pkg::CONFIG_RST;
      condensation_duty_setting     <= dpmc_pkg::DEW_DUTY_RST;
      dc_brake_level_setting        <= dpmc_pkg::BRK_LEVEL_RST;
      dc_brake_time_setting         <= dpmc_pkg::BRK_TIME_RST;
      cap_ref_user                  <= dpmc_pkg::CAP_REF_RST;
    end else if (wr) begin
      case (PADDR)
        dpmc_pkg::OFS_SELECT:    protection_maintenance_select <= PWDATA[5:0];
        dpmc_pkg::OFS_CONFIG:    config_reg                    <= PWDATA;
        dpmc_pkg::OFS_DEW_DUTY:  condensation_duty_setting     <= PWDATA[7:0];
        dpmc_pkg::OFS_BRK_LEVEL: dc_brake_level_setting        <= PWDATA[7:0];
        dpmc_pkg::OFS_BRK_TIME:  dc_brake_time_setting         <= PWDATA[15:0];
        dpmc_pkg::OFS_CAP_REF:   cap_ref_user                  <= PWDATA[15:0];
        default: ;
      endcase
    end
  end

  always_comb begin
    status = 10'h000;
    status[dpmc_pkg::ST_ALM_IN]    = ALM_IN_PHASE;
    status[dpmc_pkg::ST_ALM_OUT]   = ALM_OUT_PHASE;
    status[dpmc_pkg::ST_ALM_FAN]   = ALM_FAN_LOCK;
    status[dpmc_pkg::ST_HEAT_WARN] = OVERHEAT_WARNING_OUT;
    status[dpmc_pkg::ST_LIFE_WARN] = LIFE_WARNING_OUT;
    status[dpmc_pkg::ST_CAP_EXP]   = CAP_LIFE_EXPIRED;
    status[dpmc_pkg::ST_DEW_ACT]   = ctl.dew_active;
    status[dpmc_pkg::ST_CARRIER]   = CARRIER_LOWER;
    status[dpmc_pkg::ST_FAN_RUN]   = FAN_RUN_CMD;
    status[dpmc_pkg::ST_CAP_VALID] = cap_valid;
  end

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      PRDATA <= 32'h0000_0000;
    end else if (setup && !PWRITE) begin
      case (PADDR)
        dpmc_pkg::OFS_SELECT:    PRDATA <= {26'h0, protection_maintenance_select};
        dpmc_pkg::OFS_CONFIG:    PRDATA <= config_reg;
        dpmc_pkg::OFS_DEW_DUTY:  PRDATA <= {24'h000000, condensation_duty_setting};
        dpmc_pkg::OFS_BRK_LEVEL: PRDATA <= {24'h000000, dc_brake_level_setting};
        dpmc_pkg::OFS_BRK_TIME:  PRDATA <= {16'h0000, dc_brake_time_setting};
        dpmc_pkg::OFS_CAP_REF:   PRDATA <= {16'h0000, cap_ref_user};
        dpmc_pkg::OFS_STATUS:    PRDATA <= {22'h0, status};
        dpmc_pkg::OFS_CAP_MEAS:  PRDATA <= {16'h0000, cap_meas};
        default:                 PRDATA <= 32'h0000_0000;
      endcase
    end
  end

  // time base for brake time and discharge timing
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      tick_cnt <= 32'h0000_0000;
      tick     <= 1'b0;
    end else if (tick_cnt >= 32'(TICK_CYCLES - 1)) begin
      tick_cnt <= 32'h0000_0000;
      tick     <= 1'b1;
    end else begin
      tick_cnt <= tick_cnt + 32'h0000_0001;
      tick     <= 1'b0;
    end
  end

  assign cooling_fan_onoff_control = config_reg[dpmc_pkg::CFG_FAN_ONOFF];
  assign di_func = config_reg[dpmc_pkg::CFG_DI_FUNC_LSB +: dpmc_pkg::DI_FUNC_W];
  assign drive_stopped = !RUNNING && !RUN_CMD;

  // the terminal only means condensation prevention under its function code
  assign condensation_prevention_cmd = DI_TERMINAL && (di_func == dpmc_pkg::DEW_FUNC_CODE);

  // a commanded fan stop is not a lock; only real fans are watched
  assign fan_lock_valid = FAN_FITTED && DC_FAN_LOCK
                          && !(cooling_fan_onoff_control && !FAN_RUN_CMD);

  // one or two lost phases trip; all three is an opened contactor
  assign out_loss_partial = |OUT_PHASE_LOST && !(&OUT_PHASE_LOST);

  assign any_trip = ALM_IN_PHASE || ALM_OUT_PHASE || ALM_FAN_LOCK;

  // fan runs freely unless on/off control is on; then only when commanded, running or near heatsink overheat
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      FAN_RUN_CMD <= 1'b1;
    end else begin
      FAN_RUN_CMD <= !cooling_fan_onoff_control || RUN_CMD || RUNNING
                     || HS_OVERHEAT_NEAR;
    end
  end

  // input phase loss alarm, set wins over clear
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      ALM_IN_PHASE <= 1'b0;
    end else if (protection_maintenance_select[dpmc_pkg::SEL_IN_PHASE] && IN_PHASE_LOSS) begin
      ALM_IN_PHASE <= 1'b1;
    end else if (clr_mask[dpmc_pkg::ST_ALM_IN]) begin
      ALM_IN_PHASE <= 1'b0;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      ALM_OUT_PHASE <= 1'b0;
    end else if (protection_maintenance_select[dpmc_pkg::SEL_OUT_PHASE] && RUNNING
                 && out_loss_partial) begin
      ALM_OUT_PHASE <= 1'b1;
    end else if (clr_mask[dpmc_pkg::ST_ALM_OUT]) begin
      ALM_OUT_PHASE <= 1'b0;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      ALM_FAN_LOCK <= 1'b0;
    end else if (fan_lock_valid && !protection_maintenance_select[dpmc_pkg::SEL_FAN_CONT]) begin
      ALM_FAN_LOCK <= 1'b1;
    end else if (clr_mask[dpmc_pkg::ST_ALM_FAN]) begin
      ALM_FAN_LOCK <= 1'b0;
    end
  end

  // warnings follow the lock whatever the alarm choice
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      OVERHEAT_WARNING_OUT <= 1'b0;
      LIFE_WARNING_OUT     <= 1'b0;
    end else begin
      OVERHEAT_WARNING_OUT <= fan_lock_valid;
      LIFE_WARNING_OUT     <= fan_lock_valid || CAP_LIFE_EXPIRED;
    end
  end

  // carrier lowering trades motor noise for staying out of trip
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      CARRIER_LOWER <= 1'b0;
    end else begin
      CARRIER_LOWER <= protection_maintenance_select[dpmc_pkg::SEL_CARRIER]
                       && (HS_OVERHEAT_NEAR || OVERLOAD_NEAR);
    end
  end

  // any trip removes the output so the motor coasts
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      OUTPUT_ENABLE <= 1'b0;
    end else begin
      OUTPUT_ENABLE <= RUN_CMD && !any_trip;
    end
  end

  // condensation prevention sequencer
  assign ctl.tick    = tick;
  assign ctl.dew_go  = condensation_prevention_cmd && drive_stopped;
  assign ctl.on_time = dc_brake_time_setting;
  assign ctl.duty    = condensation_duty_setting;

  dpmc_dew_seq u_dew (
    .clk   (CORE_CLK),
    .rst_n (RST_N),
    .ctl   (ctl.dew)
  );

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      DC_INJECT_EN    <= 1'b0;
      DC_INJECT_LEVEL <= 8'h00;
    end else begin
      DC_INJECT_EN    <= ctl.dew_pulse && ctl.dew_go;
      DC_INJECT_LEVEL <= (ctl.dew_pulse && ctl.dew_go) ? dc_brake_level_setting : 8'h00;
    end
  end

  // capacitor discharge timing
  assign ctl.cap_arm = protection_maintenance_select[dpmc_pkg::SEL_CAP_JUDGE];
  assign ctl.pwr_off = POWER_OFF;
  assign ctl.bus_low = DC_BUS_LOW;
  assign cap_ref = protection_maintenance_select[dpmc_pkg::SEL_CAP_USERREF]
                   ? cap_ref_user : CAP_REF_FACTORY;

  dpmc_cap_timer u_cap (
    .clk   (CORE_CLK),
    .rst_n (RST_N),
    .ctl   (ctl.cap)
  );

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      cap_meas  <= 16'h0000;
      cap_valid <= 1'b0;
    end else if (ctl.cap_done) begin
      cap_meas  <= ctl.cap_count;
      cap_valid <= 1'b1;
    end
  end

  // a shrunken capacitor discharges faster than the reference
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      CAP_LIFE_EXPIRED <= 1'b0;
    end else if (ctl.cap_done && ctl.cap_count < cap_ref) begin
      CAP_LIFE_EXPIRED <= 1'b1;
    end else if (clr_mask[dpmc_pkg::ST_CAP_EXP]) begin
      CAP_LIFE_EXPIRED <= 1'b0;
    end
  end
endmodule : dpmc_top

// File: rtl/dpmc_pkg.sv
package dpmc_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_SELECT    = 8'h00;
  localparam logic [7:0] OFS_CONFIG    = 8'h04;
  localparam logic [7:0] OFS_DEW_DUTY  = 8'h08;
  localparam logic [7:0] OFS_BRK_LEVEL = 8'h0c;
  localparam logic [7:0] OFS_BRK_TIME  = 8'h10;
  localparam logic [7:0] OFS_CAP_REF   = 8'h14;
  localparam logic [7:0] OFS_STATUS    = 8'h18;
  localparam logic [7:0] OFS_CLEAR     = 8'h1c;
  localparam logic [7:0] OFS_CAP_MEAS  = 8'h20;

  // protection selection word bits
  localparam int SEL_W           = 6;
  localparam int SEL_CARRIER     = 0;
  localparam int SEL_IN_PHASE    = 1;
  localparam int SEL_OUT_PHASE   = 2;
  localparam int SEL_CAP_USERREF = 3;
  localparam int SEL_CAP_JUDGE   = 4;
  localparam int SEL_FAN_CONT    = 5;

  // config fields
  localparam int CFG_FAN_ONOFF = 0;
  localparam int CFG_DI_FUNC_LSB = 8;
  localparam int DI_FUNC_W = 8;
  localparam logic [7:0] DEW_FUNC_CODE = 8'h27;

  // status and clear bits
  localparam int ST_ALM_IN    = 0;
  localparam int ST_ALM_OUT   = 1;
  localparam int ST_ALM_FAN   = 2;
  localparam int ST_HEAT_WARN = 3;
  localparam int ST_LIFE_WARN = 4;
  localparam int ST_CAP_EXP   = 5;
  localparam int ST_DEW_ACT   = 6;
  localparam int ST_CARRIER   = 7;
  localparam int ST_FAN_RUN   = 8;
  localparam int ST_CAP_VALID = 9;

  // reset values
  localparam logic [5:0]  SELECT_RST    = 6'h00;
  localparam logic [31:0] CONFIG_RST    = 32'h0000_0000;
  localparam logic [7:0]  DEW_DUTY_RST  = 8'h01;
  localparam logic [7:0]  BRK_LEVEL_RST = 8'h00;
  localparam logic [15:0] BRK_TIME_RST  = 16'h0000;
  localparam logic [15:0] CAP_REF_RST   = 16'h0000;
  localparam logic [15:0] CAP_REF_FACTORY = 16'h0100;

  // timing: one time unit of the brake-time setting
  localparam int CLK_PERIOD_NS = 4;
  localparam int TICK_UNIT_NS  = 10_000_000;
  localparam int TICK_CYCLES   = TICK_UNIT_NS / CLK_PERIOD_NS;
  localparam logic [7:0] PCT_FULL = 8'h64;
endpackage : dpmc_pkg

// File: rtl/dpmc_ctl_if.sv
interface dpmc_ctl_if;
  logic        tick;
  logic        dew_go;
  logic [15:0] on_time;
  logic [7:0]  duty;
  logic        dew_active;
  logic        dew_pulse;
  logic        cap_arm;
  logic        pwr_off;
  logic        bus_low;
  logic        cap_done;
  logic [15:0] cap_count;

  modport ctrl (output tick, dew_go, on_time, duty, cap_arm, pwr_off, bus_low,
                input  dew_active, dew_pulse, cap_done, cap_count);
  modport dew  (input  tick, dew_go, on_time, duty,
                output dew_active, dew_pulse);
  modport cap  (input  tick, cap_arm, pwr_off, bus_low,
                output cap_done, cap_count);
endinterface : dpmc_ctl_if

// File: rtl/dpmc_dew_seq.sv
module dpmc_dew_seq (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // link to controller
  dpmc_ctl_if.dew  ctl
);
  typedef enum logic [1:0] {DEW_IDLE, DEW_ON, DEW_OFF} dpmc_dew_t;
  dpmc_dew_t   state;
  logic [15:0] on_cnt;
  logic [23:0] acc;
  logic [23:0] off_target;
  logic [7:0]  rest;

  // off time chosen so that on / (on + off) equals the duty
  assign rest       = (ctl.duty >= dpmc_pkg::PCT_FULL) ? 8'h00 : dpmc_pkg::PCT_FULL - ctl.duty;
  assign off_target = 24'(ctl.on_time * rest);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state  <= DEW_IDLE;
      on_cnt <= 16'h0000;
      acc    <= 24'h000000;
    end else if (!ctl.dew_go) begin
      state  <= DEW_IDLE;
      on_cnt <= 16'h0000;
      acc    <= 24'h000000;
    end else begin
      case (state)
        DEW_IDLE: begin
          if (ctl.duty != 8'h00 && ctl.on_time != 16'h0000) begin
            state  <= DEW_ON;
            on_cnt <= 16'h0000;
          end
        end
        DEW_ON: begin
          if (ctl.tick) begin
            if (on_cnt + 16'h0001 >= ctl.on_time) begin
              state <= DEW_OFF;
              acc   <= 24'h000000;
            end else begin
              on_cnt <= on_cnt + 16'h0001;
            end
          end
        end
        DEW_OFF: begin
          if (ctl.tick) begin
            if (acc + 24'(ctl.duty) >= off_target) begin
              state  <= DEW_ON;
              on_cnt <= 16'h0000;
            end else begin
              acc <= acc + 24'(ctl.duty);
            end
          end
        end
        default: state <= DEW_IDLE;
      endcase
    end
  end

  assign ctl.dew_active = ctl.dew_go;
  assign ctl.dew_pulse  = (state == DEW_ON);
endmodule : dpmc_dew_seq

// File: rtl/dpmc_cap_timer.sv
module dpmc_cap_timer (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // link to controller
  dpmc_ctl_if.cap  ctl
);
  typedef enum logic [1:0] {CAP_IDLE, CAP_RUN, CAP_WAIT} dpmc_cap_t;
  dpmc_cap_t   state;
  logic [15:0] cnt;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state         <= CAP_IDLE;
      cnt           <= 16'h0000;
      ctl.cap_done  <= 1'b0;
      ctl.cap_count <= 16'h0000;
    end else begin
      ctl.cap_done <= 1'b0;
      case (state)
        CAP_IDLE: begin
          if (ctl.cap_arm && ctl.pwr_off) begin
            state <= CAP_RUN;
            cnt   <= 16'h0000;
          end
        end
        CAP_RUN: begin
          if (!ctl.pwr_off) begin
            state <= CAP_IDLE; // power came back, measurement void
          end else if (ctl.bus_low) begin
            state         <= CAP_WAIT;
            ctl.cap_done  <= 1'b1;
            ctl.cap_count <= cnt;
          end else if (ctl.tick && cnt != 16'hffff) begin
            cnt <= cnt + 16'h0001;
          end
        end
        CAP_WAIT: begin
          if (!ctl.pwr_off) state <= CAP_IDLE;
        end
        default: state <= CAP_IDLE;
      endcase
    end
  end
endmodule : dpmc_cap_timer

// File: verif/dpmc_motor_model.sv
module dpmc_motor_model (
  // phase faults commanded by the bench
  input  wire logic [2:0] broken_phase,
  input  wire logic       contactor_open,
  // phase sense back to the drive
  output logic      [2:0] phase_lost
);
  timeunit 1ns;
  timeprecision 1ps;
  // an open output contactor drops all three phases at once
  assign phase_lost = contactor_open ? 3'h7 : broken_phase;
endmodule : dpmc_motor_model

// File: verif/dpmc_top_sva.sv
module dpmc_top_sva #(
  parameter int          TICK_CYCLES     = 4,
  parameter logic [15:0] CAP_REF_FACTORY = 16'h0100
) (
  // clock and reset
  input wire logic        CORE_CLK,
  input wire logic        RST_N,
  // apb
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [7:0]  PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic        PREADY,
  // drive state and detectors
  input wire logic        RUN_CMD,
  input wire logic        RUNNING,
  input wire logic        HS_OVERHEAT_NEAR,
  input wire logic        OVERLOAD_NEAR,
  input wire logic        IN_PHASE_LOSS,
  input wire logic [2:0]  OUT_PHASE_LOST,
  input wire logic        FAN_FITTED,
  input wire logic        DC_FAN_LOCK,
  input wire logic        DI_TERMINAL,
  // outputs
  input wire logic        OUTPUT_ENABLE,
  input wire logic        CARRIER_LOWER,
  input wire logic        FAN_RUN_CMD,
  input wire logic        DC_INJECT_EN,
  input wire logic [7:0]  DC_INJECT_LEVEL,
  input wire logic        ALM_IN_PHASE,
  input wire logic        ALM_OUT_PHASE,
  input wire logic        ALM_FAN_LOCK,
  input wire logic        OVERHEAT_WARNING_OUT,
  input wire logic        LIFE_WARNING_OUT
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [5:0]  sel;
  logic        fan_ctl, dew_go, fan_ok;
  logic [7:0]  di_func, duty, lvl;
  logic [15:0] btime;
  int          on_cnt;
  assign dew_go = DI_TERMINAL && di_func == dpmc_pkg::DEW_FUNC_CODE && !RUNNING && !RUN_CMD;
  assign fan_ok = FAN_FITTED && DC_FAN_LOCK && FAN_RUN_CMD;
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      {sel, fan_ctl, di_func, lvl, btime} <= '0;
      duty <= 8'h01;
    end else if (PSEL && PENABLE && PWRITE && PREADY) begin
      case (PADDR)
        dpmc_pkg::OFS_SELECT:    sel <= PWDATA[5:0];
        dpmc_pkg::OFS_CONFIG:    {di_func, fan_ctl} <= {PWDATA[15:8], PWDATA[0]};
        dpmc_pkg::OFS_DEW_DUTY:  duty <= PWDATA[7:0];
        dpmc_pkg::OFS_BRK_LEVEL: lvl <= PWDATA[7:0];
        dpmc_pkg::OFS_BRK_TIME:  btime <= PWDATA[15:0];
        default: ;
      endcase
    end
  end
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) on_cnt <= 0;
    else on_cnt <= DC_INJECT_EN ? on_cnt + 1 : 0;
  end
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RST_N);
  carrier_lower_a: assert property (sel[0] && (HS_OVERHEAT_NEAR || OVERLOAD_NEAR)
    |=> CARRIER_LOWER) else $error("no carrier low");
  carrier_off_a: assert property (!sel[0] |=> !CARRIER_LOWER)
    else $error("carrier low");
  in_alarm_a: assert property (sel[1] && IN_PHASE_LOSS |=> ALM_IN_PHASE)
    else $error("no in alarm");
  out_alarm_a: assert property (sel[2] && RUNNING && OUT_PHASE_LOST != 3'h0
    && OUT_PHASE_LOST != 3'h7 |=> ALM_OUT_PHASE) else $error("no out alarm");
  out_quiet_a: assert property (!ALM_OUT_PHASE && (OUT_PHASE_LOST == 3'h7 || !RUNNING
    || !sel[2]) |=> !ALM_OUT_PHASE) else $error("out false trip");
  alarm_stop_a: assert property (ALM_IN_PHASE || ALM_OUT_PHASE || ALM_FAN_LOCK
    |=> !OUTPUT_ENABLE) else $error("output on");
  fan_warn_a: assert property (fan_ok |=> OVERHEAT_WARNING_OUT && LIFE_WARNING_OUT)
    else $error("no fan warn");
  fan_alarm_a: assert property (fan_ok && !sel[5] |=> ALM_FAN_LOCK)
    else $error("no fan alarm");
  fan_cont_a: assert property (sel[5] && !ALM_FAN_LOCK |=> !ALM_FAN_LOCK)
    else $error("fan alarm");
  fan_stop_a: assert property (fan_ctl && !FAN_RUN_CMD |=> !OVERHEAT_WARNING_OUT)
    else $error("fan warn");
  fan_start_a: assert property (RUN_CMD |=> FAN_RUN_CMD)
    else $error("fan off");
  dew_start_a: assert property ($rose(dew_go) && duty != 8'h00 && btime != 16'h0000
    |-> ##[1:2] DC_INJECT_EN) else $error("no pulse");
  dew_stop_a: assert property (!dew_go |=> !DC_INJECT_EN)
    else $error("pulse on");
  dew_level_a: assert property (DC_INJECT_LEVEL == (DC_INJECT_EN ? lvl : 8'h00))
    else $error("pulse level");
  dew_on_a: assert property ($fell(DC_INJECT_EN) |-> on_cnt <= btime * TICK_CYCLES + 1)
    else $error("pulse long");
  cover property (ALM_OUT_PHASE);
  cover property ($rose(DC_INJECT_EN));
  cover property (ALM_FAN_LOCK && LIFE_WARNING_OUT);
endmodule : dpmc_top_sva

bind dpmc_top dpmc_top_sva #(.TICK_CYCLES(TICK_CYCLES), .CAP_REF_FACTORY(CAP_REF_FACTORY))
  u_sva (.*);

// File: verif/tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TK = 4;
  localparam logic [7:0] SEL = dpmc_pkg::OFS_SELECT;
  localparam logic [7:0] CLR = dpmc_pkg::OFS_CLEAR;
  logic        clk, rst_n, psel, penable, pwrite, pready, pslverr, contactor, se;
  logic [7:0]  paddr, inj_lvl;
  logic [31:0] pwdata, prdata, q;
  logic        run_cmd, running, hs_near, ol_near, in_loss, fan_fit, fan_lock, pwr_off;
  logic        bus_low, di, oe, car_low, fan_run, inj_en, alm_in, alm_out, alm_fan;
  logic        hot, life_warn, cap_exp;
  logic [2:0]  broken, lost;
  logic [15:0] rnd;
  int          err_total, tests_run, cnt, lv, ex;

  dpmc_top #(.TICK_CYCLES(TK), .CAP_REF_FACTORY(16'h0003)) dut (
    .CORE_CLK(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .RUN_CMD(run_cmd), .RUNNING(running), .HS_OVERHEAT_NEAR(hs_near), .OVERLOAD_NEAR(ol_near),
    .IN_PHASE_LOSS(in_loss), .OUT_PHASE_LOST(lost), .FAN_FITTED(fan_fit), .DC_FAN_LOCK(fan_lock),
    .POWER_OFF(pwr_off), .DC_BUS_LOW(bus_low), .DI_TERMINAL(di), .OUTPUT_ENABLE(oe),
    .CARRIER_LOWER(car_low), .FAN_RUN_CMD(fan_run), .DC_INJECT_EN(inj_en),
    .DC_INJECT_LEVEL(inj_lvl), .ALM_IN_PHASE(alm_in), .ALM_OUT_PHASE(alm_out),
    .ALM_FAN_LOCK(alm_fan), .OVERHEAT_WARNING_OUT(hot), .LIFE_WARNING_OUT(life_warn),
    .CAP_LIFE_EXPIRED(cap_exp));
  dpmc_motor_model motor (.broken_phase(broken), .contactor_open(contactor), .phase_lost(lost));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  // off time rounded up to whole ticks so the duty never overshoots
  function automatic int off_cyc(input int t, input int d);
    return (t * (100 - d) + d - 1) / d * TK;
  endfunction : off_cyc

  task automatic complete_run();
    $display("tests %0d errors %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : complete_run

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH %0t %s got %0h", $time, m, got);
    end
  endtask : chk

  task automatic give_up(input string m);
    chk(0, 1, m);
    complete_run();
  endtask : give_up

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    q = prdata;
    se = pslverr;
    {psel, penable} <= 2'b00;
    if (n >= 50) give_up("apb");
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc

  task automatic wait_en(input logic v);
    cnt = 0;
    while (inj_en !== v) begin
      @(posedge clk);
      cnt++;
      if (cnt > 400) give_up("pulse wait");
    end
  endtask : wait_en

  initial begin
    {rst_n, psel, penable, pwrite, paddr, pwdata, broken, contactor} = '0;
    {run_cmd, running, hs_near, ol_near, in_loss, fan_fit, fan_lock, pwr_off, bus_low, di} = '0;
    {err_total, tests_run} = '0;
    rnd = 16'd62315;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    apb(1'b0, SEL, 0);
    chk(q, 0, "sel rst");
    apb(1'b0, dpmc_pkg::OFS_DEW_DUTY, 0);
    chk(q, 1, "duty rst");
    apb(1'b0, 8'h40, 0);
    chk(q, 0, "unmapped");
    chk(se, 1, "slverr");
    for (int i = 0; i < 10; i++) begin
      rnd = lfsr(rnd);
      lv = (i == 0) ? 63 : (i == 1) ? 0 : rnd[5:0];
      {hs_near, ol_near} <= rnd[7:6];
      wr(SEL, lv);
      apb(1'b0, SEL, 0);
      chk(q, lv, "sel");
      chk(car_low, lv[0] & (rnd[7] | rnd[6]), "carrier");
    end
    {hs_near, ol_near} <= 2'b00;
    wr(SEL, 0);
    {in_loss, run_cmd} <= 2'b11;
    cyc(3);
    chk({alm_in, oe}, 2'b01, "in off");
    wr(SEL, 2);
    cyc(3);
    chk({alm_in, oe}, 2'b10, "in trip");
    in_loss <= 1'b0;
    wr(CLR, 32'h27);
    cyc(3);
    chk({alm_in, oe}, 2'b01, "in clr");
    wr(SEL, 4);
    {running, contactor} <= 2'b11;
    cyc(3);
    chk(alm_out, 0, "contactor");
    contactor <= 1'b0;
    broken <= 3'h2;
    cyc(3);
    chk({alm_out, oe}, 2'b10, "out trip");
    {broken, running} <= 4'h0;
    wr(CLR, 32'h27);
    wr(SEL, 32'h20);
    {fan_fit, fan_lock} <= 2'b11;
    cyc(3);
    chk({alm_fan, hot, life_warn}, 3'b011, "fan cont");
    wr(SEL, 0);
    cyc(3);
    chk({alm_fan, hot, life_warn, oe}, 4'b1110, "fan alarm");
    run_cmd <= 1'b0;
    wr(dpmc_pkg::OFS_CONFIG, 1);
    wr(CLR, 32'h27);
    cyc(3);
    chk({fan_run, alm_fan, hot}, 3'b000, "fan stop");
    run_cmd <= 1'b1;
    cyc(4);
    chk({fan_run, alm_fan, hot}, 3'b111, "fan start");
    {run_cmd, fan_lock} <= 2'b00;
    wr(CLR, 32'h27);
    for (int i = 0; i < 2; i++) begin
      wr(dpmc_pkg::OFS_CAP_REF, 20);
      wr(SEL, 32'h10 | (i << 3));
      pwr_off <= 1'b1;
      cyc(10 * TK);
      bus_low <= 1'b1;
      cyc(3);
      chk(cap_exp, i, "cap life");
      {pwr_off, bus_low} <= 2'b00;
      cyc(2);
    end
    wr(CLR, 32'h20);
    wr(SEL, 0);
    di <= 1'b1;
    wr(dpmc_pkg::OFS_BRK_TIME, 2);
    cyc(20);
    chk(inj_en, 0, "bad func");
    running <= 1'b1;
    wr(dpmc_pkg::OFS_CONFIG, 32'h2700);
    cyc(20);
    chk(inj_en, 0, "running");
    running <= 1'b0;
    for (int i = 0; i < 2; i++) begin
      rnd = lfsr(rnd);
      di <= 1'b0;
      wr(dpmc_pkg::OFS_BRK_LEVEL, rnd[7:0]);
      wr(dpmc_pkg::OFS_DEW_DUTY, 50 - 25 * i);
      di <= 1'b1;
      wait_en(1'b1);
      chk(inj_lvl, rnd[7:0], "level");
      wait_en(1'b0);
      wait_en(1'b1);
      wait_en(1'b0);
      chk(cnt >= 2 * TK - 1 && cnt <= 2 * TK + 1, 1, "on time");
      wait_en(1'b1);
      ex = off_cyc(2, 50 - 25 * i);
      chk(cnt >= ex - 1 && cnt <= ex + 1, 1, "interval");
    end
    run_cmd <= 1'b1;
    cyc(3);
    chk(inj_en, 0, "run stop");
    run_cmd <= 1'b0;
    wait_en(1'b1);
    di <= 1'b0;
    cyc(3);
    chk(inj_en, 0, "cmd off");
    complete_run();
  end
endmodule : tb_top
